//--- core/output_command_logic.sv
// one output channel: control selection, scaling, digital, enable, faults
`default_nettype none
module output_command_logic #(
	parameter int NSRC = 4,
	parameter int MS_CYCLES = out_cmd_pkg::MS_CYC
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	// configuration
	input  wire out_cmd_pkg::out_cfg_s cfg_in,
	input  wire logic [1:0]  filt_type_in,
	input  wire logic [15:0] filt_const_in,
	input  wire logic [$clog2(NSRC)-1:0] ctl_sel_in,
	input  wire logic [$clog2(NSRC)-1:0] freq_sel_in,
	input  wire logic [$clog2(NSRC)-1:0] en_sel_in,
	input  wire logic [$clog2(NSRC)-1:0] ovr_sel_in,
	input  wire logic        ovr_used_in,
	input  wire logic        supply_shutdown_en_in,
	input  wire logic        overtemp_shutdown_en_in,
	input  wire logic        fixed_wr_in,
	input  wire logic [15:0] fixed_wr_data_in,
	// signal sources: raw values with their ranges
	input  wire logic [NSRC*16-1:0] src_val_in,
	input  wire logic [NSRC*16-1:0] src_min_in,
	input  wire logic [NSRC*16-1:0] src_max_in,
	input  wire logic [NSRC-1:0]    src_digital_in,
	input  wire logic [NSRC-1:0]    src_fault_in,
	input  wire logic        sample_valid_in,
	// system status
	input  wire logic        supply_fault_in,
	input  wire logic        overtemp_in,
	input  wire logic [15:0] current_fb_in,
	// outputs
	output logic [15:0]      out_value_out,
	output logic             out_digital_out,
	output logic [15:0]      out_freq_out,
	output logic [15:0]      fixed_setting_out,
	output logic             out_active_out,
	output logic             current_fault_out,
	output logic [15:0]      filtered_out
);
	logic [15:0] norm [NSRC];
	logic        tick;
	logic [15:0] ctl_x, freq_x;
	logic [31:0] span_prod;
	logic [15:0] lin_target;
	logic        cmd_on, en_raw, ovr_raw;
	logic        enabled, ovr_active, in_fault, shutdown;
	logic        dig_cmd, dig_cmd_d, dig_state, dig_delayed, blink_ph;
	logic [15:0] dly_cnt, blink_cnt, ramp_acc;
	logic [15:0] ramped, hold_val, step_up, step_dn, range_abs;
	logic [7:0]  type_d;
	logic        is_digital, is_linear, is_current;
	logic [15:0] next_value;
	logic        next_active;

	ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.tick_out   (tick)
	);

	input_avg_filter #(.W(16)) u_filt (
		.sys_clk_in      (sys_clk_in),
		.reset_n_in      (reset_n_in),
		.filt_type_in    (filt_type_in),
		.filt_const_in   (filt_const_in),
		.sample_valid_in (sample_valid_in),
		.sample_in       (ctl_x),
		.filtered_out    (filtered_out)
	);

	// normalise each source to 0..1 in Q1.15, saturating at its range
	for (genvar i = 0; i < NSRC; i++)
	begin : g_norm
		logic [15:0] v, lo, hi;
		logic [31:0] q;
		assign v = src_val_in[i*16 +: 16];
		assign lo = src_min_in[i*16 +: 16];
		assign hi = src_max_in[i*16 +: 16];
		assign q = (hi > lo) ? ({16'h0000, v - lo} << out_cmd_pkg::FRAC_W)
			/ {16'h0000, hi - lo} : 32'h0000_0000;
		always_comb
		begin
			if (src_digital_in[i])
				norm[i] = v[0] ? out_cmd_pkg::ONE_VAL : 16'h0000;
			else if (v <= lo)
				norm[i] = 16'h0000;
			else if (v >= hi)
				norm[i] = out_cmd_pkg::ONE_VAL;
			else
				norm[i] = q[15:0];
		end
	end

	assign ctl_x = norm[ctl_sel_in];
	assign freq_x = norm[freq_sel_in];
	assign en_raw = norm[en_sel_in][15];
	assign ovr_raw = norm[ovr_sel_in][15];

	assign is_digital = (cfg_in.out_type == out_cmd_pkg::OT_DIGITAL);
	assign is_current = (cfg_in.out_type == out_cmd_pkg::OT_I_0_20)
		|| (cfg_in.out_type == out_cmd_pkg::OT_I_4_20);
	assign is_linear = ((cfg_in.out_type >= out_cmd_pkg::OT_V_LO)
		&& (cfg_in.out_type <= out_cmd_pkg::OT_V_HI)) || is_current
		|| (cfg_in.out_type == out_cmd_pkg::OT_FREQ)
		|| (cfg_in.out_type == out_cmd_pkg::OT_PWM)
		|| (cfg_in.out_type == out_cmd_pkg::OT_MIXED);

	// y = ymin + (ymax - ymin) * x; signed span gives inverse tracking
	assign span_prod = 32'($signed({16'h0000, ctl_x})
		* ($signed({16'h0000, cfg_in.y_max}) - $signed({16'h0000, cfg_in.y_min})));
	assign lin_target = 16'(cfg_in.y_min
		+ 16'($signed(span_prod) >>> out_cmd_pkg::FRAC_W));

	// mixed type frequency bounded by its own min and max
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			out_freq_out <= 16'h0000;
		else if (cfg_in.out_type == out_cmd_pkg::OT_MIXED)
			out_freq_out <= 16'(cfg_in.freq_min + 16'((32'(freq_x)
				* 32'(16'(cfg_in.freq_max - cfg_in.freq_min)))
				>> out_cmd_pkg::FRAC_W));
		else
			out_freq_out <= 16'h0000;
	end

	// fixed setting reloads its default on a type change
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
		begin
			type_d <= out_cmd_pkg::OT_DISABLED;
			fixed_setting_out <= out_cmd_pkg::FIXED_FREQ_DUTY_DEF;
		end
		else
		begin
			type_d <= cfg_in.out_type;
			if (type_d != cfg_in.out_type)
				fixed_setting_out <= (cfg_in.out_type == out_cmd_pkg::OT_PWM)
					? out_cmd_pkg::FIXED_PWM_FREQ_DEF
					: out_cmd_pkg::FIXED_FREQ_DUTY_DEF;
			else if (fixed_wr_in)
				fixed_setting_out <= fixed_wr_data_in;
		end
	end

	// analog-to-digital command with hysteresis band between ends
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			cmd_on <= 1'b0;
		else if (ctl_x == 16'h0000)
			cmd_on <= 1'b0;
		else if (ctl_x >= out_cmd_pkg::ONE_VAL)
			cmd_on <= 1'b1;
	end

	assign enabled = !cfg_in.en_used ? 1'b1
		: ((cfg_in.en_resp == out_cmd_pkg::EN_OFF_SHUT)
		|| (cfg_in.en_resp == out_cmd_pkg::EN_OFF_HOLD)) ? !en_raw : en_raw;
	assign ovr_active = ovr_used_in && (ovr_raw ^ cfg_in.ovr_resp);
	assign in_fault = src_fault_in[ctl_sel_in]
		|| (cfg_in.en_used && src_fault_in[en_sel_in])
		|| (ovr_used_in && src_fault_in[ovr_sel_in]);
	assign shutdown = (supply_shutdown_en_in && supply_fault_in)
		|| (overtemp_shutdown_en_in && overtemp_in);

	// digital path: latch edges, delay on chosen edge, blink
	assign dig_cmd = cmd_on;
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
		begin
			dig_cmd_d <= 1'b0;
			dig_state <= 1'b0;
			dig_delayed <= 1'b0;
			dly_cnt <= 16'h0000;
			blink_cnt <= 16'h0000;
			blink_ph <= 1'b0;
		end
		else
		begin
			dig_cmd_d <= dig_cmd;
			if (dig_cmd && !dig_cmd_d)
				dig_state <= !dig_state;
			if (dig_cmd == dig_delayed)
				dly_cnt <= 16'h0000;
			else if (cfg_in.dig_delay_ms == 16'h0000
				|| dig_cmd == cfg_in.delay_pol)
				dig_delayed <= dig_cmd;
			else if (tick)
			begin
				if (dly_cnt + 16'h0001 >= cfg_in.dig_delay_ms)
					dig_delayed <= dig_cmd;
				else
					dly_cnt <= dly_cnt + 16'h0001;
			end
			if (!dig_cmd)
			begin
				blink_cnt <= 16'h0000;
				blink_ph <= 1'b0;
			end
			else if (tick)
			begin
				if (blink_cnt + 16'h0001 >= cfg_in.blink_ms)
				begin
					blink_cnt <= 16'h0000;
					blink_ph <= !blink_ph;
				end
				else
					blink_cnt <= blink_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			out_digital_out <= 1'b0;
		else if (!is_digital || shutdown || (in_fault
			&& cfg_in.fault_resp == out_cmd_pkg::FR_SHUT))
			out_digital_out <= 1'b0;
		else
			case (out_cmd_pkg::dig_resp_e'(cfg_in.dig_resp))
				out_cmd_pkg::DR_NORMAL: out_digital_out <= dig_delayed;
				out_cmd_pkg::DR_INVERSE: out_digital_out <= !dig_cmd;
				out_cmd_pkg::DR_LATCHED: out_digital_out <= dig_state;
				out_cmd_pkg::DR_BLINK: out_digital_out <= dig_cmd && !blink_ph;
				default: out_digital_out <= 1'b0;
			endcase
	end

	// ramp: step per ms = |range| / ramp ms with bit 0 forced to one, so at least one count
	assign range_abs = (cfg_in.y_max >= cfg_in.y_min)
		? cfg_in.y_max - cfg_in.y_min : cfg_in.y_min - cfg_in.y_max;
	assign step_up = (cfg_in.ramp_up_ms == 16'h0000) ? 16'hffff
		: ((range_abs / cfg_in.ramp_up_ms) | 16'h0001);
	assign step_dn = (cfg_in.ramp_dn_ms == 16'h0000) ? 16'hffff
		: ((range_abs / cfg_in.ramp_dn_ms) | 16'h0001);

	// priority chain picks the target before ramping
	always_comb
	begin
		next_value = lin_target;
		next_active = is_linear;
		if (shutdown || (in_fault && cfg_in.fault_resp == out_cmd_pkg::FR_SHUT))
			next_active = 1'b0;
		else if (in_fault && cfg_in.fault_resp == out_cmd_pkg::FR_VALUE)
			next_value = cfg_in.fault_value;
		else if (in_fault)
			next_value = hold_val;
		else if (ovr_active)
			next_value = cfg_in.forced_output_value;
		else if (!enabled)
			case (out_cmd_pkg::en_resp_e'(cfg_in.en_resp))
				out_cmd_pkg::EN_ON_MIN,
				out_cmd_pkg::EN_ON_RMIN: next_value = cfg_in.y_min;
				out_cmd_pkg::EN_ON_MAX,
				out_cmd_pkg::EN_ON_RMAX: next_value = cfg_in.y_max;
				out_cmd_pkg::EN_ON_HOLD,
				out_cmd_pkg::EN_OFF_HOLD: next_value = hold_val;
				default: next_active = 1'b0;
			endcase
	end

	// jumps bypass the ramp; only control path, ramp-to and hold codes ramp
	assign ramp_acc = (next_value > ramped)
		? ((next_value - ramped > step_up) ? ramped + step_up : next_value)
		: ((ramped - next_value > step_dn) ? ramped - step_dn : next_value);
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
		begin
			ramped <= 16'h0000;
			hold_val <= 16'h0000;
			out_active_out <= 1'b0;
			out_value_out <= 16'h0000;
		end
		else
		begin
			out_active_out <= next_active;
			if (!next_active)
				ramped <= 16'h0000;
			else if (in_fault || ovr_active || (!enabled && (cfg_in.en_resp
				== out_cmd_pkg::EN_ON_MIN || cfg_in.en_resp
				== out_cmd_pkg::EN_ON_MAX)))
				ramped <= next_value;
			else if (tick)
				ramped <= ramp_acc;
			if (!in_fault && enabled && !ovr_active)
				hold_val <= ramped;
			out_value_out <= next_active ? ramped : 16'h0000;
		end
	end

	// current output fault: feedback outside tolerance of command
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			current_fault_out <= 1'b0;
		else
			current_fault_out <= is_current && out_active_out
				&& (((current_fb_in > out_value_out)
				? current_fb_in - out_value_out
				: out_value_out - current_fb_in) > cfg_in.current_tol);
	end
endmodule : output_command_logic
`default_nettype wire

//--- shared/out_cmd_pkg.sv
// shared constants and carrier types for the output command processor
`default_nettype none
package out_cmd_pkg;
	localparam int VAL_W = 16;
	localparam int FRAC_W = 15;
	localparam logic [15:0] ONE_VAL = 16'h8000;
	localparam int CLK_MHZ = 100;
	localparam int MS_CYC = CLK_MHZ * 1000;
	localparam logic [7:0] OT_DISABLED = 8'h00;
	localparam logic [7:0] OT_V_LO = 8'h0c;
	localparam logic [7:0] OT_V_HI = 8'h0f;
	localparam logic [7:0] OT_I_0_20 = 8'h14;
	localparam logic [7:0] OT_I_4_20 = 8'h15;
	localparam logic [7:0] OT_FREQ = 8'h28;
	localparam logic [7:0] OT_PWM = 8'h32;
	localparam logic [7:0] OT_DIGITAL = 8'h3c;
	localparam logic [7:0] OT_MIXED = 8'h46;
	localparam logic [15:0] FIXED_FREQ_DUTY_DEF = 16'h4000;
	localparam logic [15:0] FIXED_PWM_FREQ_DEF = 16'h01f4;
	localparam logic [1:0] FILT_NONE = 2'h0;
	localparam logic [1:0] FILT_MOVING = 2'h1;
	localparam logic [1:0] FILT_REPEAT = 2'h2;
	typedef enum logic [1:0] {
		DR_NORMAL = 2'h0,
		DR_INVERSE = 2'h1,
		DR_LATCHED = 2'h2,
		DR_BLINK = 2'h3
	} dig_resp_e;
	typedef enum logic [2:0] {
		EN_ON_SHUT = 3'h0,
		EN_OFF_SHUT = 3'h1,
		EN_ON_MIN = 3'h2,
		EN_ON_MAX = 3'h3,
		EN_ON_RMIN = 3'h4,
		EN_ON_RMAX = 3'h5,
		EN_ON_HOLD = 3'h6,
		EN_OFF_HOLD = 3'h7
	} en_resp_e;
	localparam logic [1:0] FR_SHUT = 2'h0;
	localparam logic [1:0] FR_VALUE = 2'h1;
	localparam logic [1:0] FR_HOLD = 2'h2;
	// output-side setpoints; levels in output units, times in ms
	typedef struct packed {
		logic [7:0] out_type;
		logic [15:0] y_min;
		logic [15:0] y_max;
		logic [15:0] ramp_up_ms;
		logic [15:0] ramp_dn_ms;
		logic [1:0] dig_resp;
		logic [15:0] dig_delay_ms;
		logic delay_pol;
		logic [15:0] blink_ms;
		logic [2:0] en_resp;
		logic en_used;
		logic ovr_resp;
		logic [15:0] forced_output_value;
		logic [1:0] fault_resp;
		logic [15:0] fault_value;
		logic [15:0] freq_min;
		logic [15:0] freq_max;
		logic [15:0] current_tol;
	} out_cfg_s;
endpackage : out_cmd_pkg
`default_nettype wire

//--- core/input_avg_filter.sv
// averaging filter for one measured input: moving or repeating
`default_nettype none
module input_avg_filter #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         sys_clk_in,
	input  wire logic         reset_n_in,
	// setup
	input  wire logic [1:0]   filt_type_in,
	input  wire logic [15:0]  filt_const_in,
	// sample stream
	input  wire logic         sample_valid_in,
	input  wire logic [W-1:0] sample_in,
	output logic [W-1:0]      filtered_out
);
	logic [W+15:0] acc;
	logic [15:0]   count;
	logic [15:0]   n_eff;
	logic signed [W+1:0] diff;
	logic [W+15:0] quot;

	assign n_eff = (filt_const_in == 16'h0000) ? 16'h0001 : filt_const_in;
	assign diff = $signed({2'b00, sample_in}) - $signed({2'b00, filtered_out});

	always_comb
	begin
		quot = (acc + {16'h0000, sample_in}) / {{W{1'b0}}, n_eff};
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
		begin
			acc <= '0;
			count <= 16'h0000;
			filtered_out <= '0;
		end
		else if (sample_valid_in)
		begin
			case (filt_type_in)
				out_cmd_pkg::FILT_MOVING:
					filtered_out <= W'($signed({2'b00, filtered_out})
						+ diff / $signed({2'b00, n_eff}));
				out_cmd_pkg::FILT_REPEAT:
					if (count + 16'h0001 >= n_eff)
					begin
						filtered_out <= quot[W-1:0];
						acc <= '0;
						count <= 16'h0000;
					end
					else
					begin
						acc <= acc + {16'h0000, sample_in};
						count <= count + 16'h0001;
					end
				default:
					filtered_out <= sample_in;
			endcase
		end
	end
endmodule : input_avg_filter
`default_nettype wire

//--- core/ms_tick.sv
// one-cycle tick every millisecond
`default_nettype none
module ms_tick #(
	parameter int CYCLES = out_cmd_pkg::MS_CYC
) (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	// tick
	output logic      tick_out
);
	logic [31:0] cnt;

	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
		begin
			cnt <= 32'h0000_0000;
			tick_out <= 1'b0;
		end
		else if (cnt >= 32'(CYCLES - 1))
		begin
			cnt <= 32'h0000_0000;
			tick_out <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 32'h0000_0001;
			tick_out <= 1'b0;
		end
	end
endmodule : ms_tick
`default_nettype wire

//--- tb/load_model.sv
// load model: returns measured current feedback for the drive level
`default_nettype none
module load_model (
	// clock
	input  wire logic        sys_clk_in,
	// drive and injected sensing error
	input  wire logic [15:0] drive_in,
	input  wire logic [15:0] err_in,
	// feedback
	output logic      [15:0] fb_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle of lag, like a real sense path; err_in fakes a bad load
	always_ff @(posedge sys_clk_in)
		fb_out <= drive_in + err_in;
endmodule : load_model
`default_nettype wire

//--- tb/out_cmd_checker.sv
// port-level assertions for the output command processor
`default_nettype none
module out_cmd_checker #(
	parameter int NSRC      = 4,
	parameter int MS_CYCLES = 10
) (
	// clock and reset
	input wire logic                   sys_clk_in,
	input wire logic                   reset_n_in,
	// watched inputs
	input wire out_cmd_pkg::out_cfg_s  cfg_in,
	input wire logic [$clog2(NSRC)-1:0] ctl_sel_in,
	input wire logic [NSRC-1:0]        src_fault_in,
	input wire logic                   fixed_wr_in,
	input wire logic [15:0]            fixed_wr_data_in,
	input wire logic                   supply_shutdown_en_in,
	input wire logic                   supply_fault_in,
	input wire logic                   overtemp_shutdown_en_in,
	input wire logic                   overtemp_in,
	// watched outputs
	input wire logic [15:0]            out_value_out,
	input wire logic                   out_active_out,
	input wire logic                   out_digital_out,
	input wire logic [15:0]            out_freq_out,
	input wire logic [15:0]            fixed_setting_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// slow paths settle within one ms tick plus two register stages
	localparam int T = MS_CYCLES + 2;
	logic shut;
	logic analog_ok;
	logic type_off;
	logic not_dig;
	logic not_mixed;
	logic ctl_fault;
	assign shut = (supply_shutdown_en_in && supply_fault_in)
		|| (overtemp_shutdown_en_in && overtemp_in);
	assign type_off = cfg_in.out_type == out_cmd_pkg::OT_DISABLED;
	assign not_dig = cfg_in.out_type != out_cmd_pkg::OT_DIGITAL;
	assign not_mixed = cfg_in.out_type != out_cmd_pkg::OT_MIXED;
	assign analog_ok = !type_off && not_dig && !shut;
	assign ctl_fault = src_fault_in[ctl_sel_in];
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence s_shut_req;
		shut;
	endsequence
	sequence s_out_off;
		out_value_out == 16'h0000 && !out_active_out;
	endsequence
	a_global_shut_off: assert property (
		s_shut_req |-> ##[1:T] s_out_off)
		else $error("output not off under shutdown");
	a_disabled_idle: assert property (
		type_off |-> ##[1:T] s_out_off)
		else $error("disabled type still drives");
	a_fault_shut_off: assert property (
		ctl_fault && cfg_in.fault_resp == out_cmd_pkg::FR_SHUT
		|-> ##[1:T] out_value_out == 16'h0000)
		else $error("fault shutoff missing");
	a_fault_value_out: assert property (
		ctl_fault && cfg_in.fault_resp == out_cmd_pkg::FR_VALUE
		&& analog_ok |-> ##[1:T] out_value_out == cfg_in.fault_value)
		else $error("fault value not applied");
	a_fixed_write_taken: assert property (
		fixed_wr_in && $stable(cfg_in.out_type)
		|=> fixed_setting_out == $past(fixed_wr_data_in))
		else $error("fixed setting write lost");
	a_type_reload_pwm: assert property (
		$changed(cfg_in.out_type) && cfg_in.out_type == out_cmd_pkg::OT_PWM
		|-> ##[1:2]
		fixed_setting_out == out_cmd_pkg::FIXED_PWM_FREQ_DEF)
		else $error("fixed setting not reloaded");
	a_digital_quiet: assert property (
		not_dig [*3] |-> !out_digital_out)
		else $error("digital output on for other type");
	a_freq_quiet: assert property (
		not_mixed [*3] |-> out_freq_out == 16'h0000)
		else $error("frequency output for other type");
	a_freq_bounded: assert property (
		!not_mixed [*3] |-> out_freq_out >= cfg_in.freq_min
		&& out_freq_out <= cfg_in.freq_max)
		else $error("mixed frequency out of bounds");
endmodule : out_cmd_checker
bind output_command_logic out_cmd_checker #(
	.NSRC(NSRC),
	.MS_CYCLES(MS_CYCLES)
) chk_u (
	.sys_clk_in              (sys_clk_in),
	.reset_n_in              (reset_n_in),
	.cfg_in                  (cfg_in),
	.ctl_sel_in              (ctl_sel_in),
	.src_fault_in            (src_fault_in),
	.fixed_wr_in             (fixed_wr_in),
	.fixed_wr_data_in        (fixed_wr_data_in),
	.supply_shutdown_en_in   (supply_shutdown_en_in),
	.supply_fault_in         (supply_fault_in),
	.overtemp_shutdown_en_in (overtemp_shutdown_en_in),
	.overtemp_in             (overtemp_in),
	.out_value_out           (out_value_out),
	.out_active_out          (out_active_out),
	.out_digital_out         (out_digital_out),
	.out_freq_out            (out_freq_out),
	.fixed_setting_out       (fixed_setting_out)
);
`default_nettype wire

//--- tb/output_command_logic_bench.sv
// self-checking bench for the output command processor
`default_nettype none
module output_command_logic_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	out_cmd_pkg::out_cfg_s cfg = '0;
	logic [1:0]  ft = 2'h0;
	logic [15:0] fc = 16'h0001;
	logic        ovr_used = 1'b0, sup_en = 1'b0, ot_en = 1'b0, fwr = 1'b0;
	logic [15:0] fdat = 16'h0000, ferr = 16'h0000, fb;
	logic [63:0] sval = '0;
	logic [63:0] smin = '0, smax = {4{16'h8000}};
	logic [3:0]  sdig = '0, sflt = '0;
	logic        svalid = 1'b0, sup_flt = 1'b0, ot = 1'b0;
	logic [15:0] oval, ofreq, ofix, filt;
	logic        odig, oact, ifault, prev;
	int          failures = 0, tests_run = 0, n;
	logic [7:0]  types [9] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h14,
		8'h15, 8'h28, 8'h32, 8'h46};
	// entry: response code, enable level, expected output
	logic [23:0] etab [10] = '{24'h000000, 24'h110000, 24'h100f00,
		24'h200100, 24'h300f00, 24'h400100, 24'h500f00, 24'h610f00,
		24'h700f00, 24'h600f00};
	logic [15:0] fexp [3] = '{16'h0000, 16'h0555, 16'h0f00};
	always #5 sys_clk_in = ~sys_clk_in;
	output_command_logic #(.NSRC(4), .MS_CYCLES(10)) dut_u (
		.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cfg_in(cfg),
		.filt_type_in(ft), .filt_const_in(fc), .ctl_sel_in(2'h0),
		.freq_sel_in(2'h3), .en_sel_in(2'h2), .ovr_sel_in(2'h1),
		.ovr_used_in(ovr_used), .supply_shutdown_en_in(sup_en),
		.overtemp_shutdown_en_in(ot_en), .fixed_wr_in(fwr),
		.fixed_wr_data_in(fdat), .src_val_in(sval), .src_min_in(smin),
		.src_max_in(smax), .src_digital_in(sdig),
		.src_fault_in(sflt), .sample_valid_in(svalid),
		.supply_fault_in(sup_flt), .overtemp_in(ot), .current_fb_in(fb),
		.out_value_out(oval), .out_digital_out(odig), .out_freq_out(ofreq),
		.fixed_setting_out(ofix), .out_active_out(oact),
		.current_fault_out(ifault), .filtered_out(filt));
	load_model load_u (.sys_clk_in(sys_clk_in), .drive_in(oval),
		.err_in(ferr), .fb_out(fb));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk_in);
	endtask : cyc
	task automatic set_src(input int s, input logic [15:0] v);
		sval[s*16 +: 16] = v;
		cyc(30);
	endtask : set_src
	task automatic do_reset;
		reset_n_in = 1'b0;
		cyc(10);
		reset_n_in = 1'b1;
	endtask : do_reset
	// value settles before the strobe, as the filter may see it late
	task automatic sample(input logic [15:0] v);
		sval[15:0] = v;
		cyc(3);
		svalid = 1'b1;
		cyc(1);
		svalid = 1'b0;
		cyc(3);
	endtask : sample
	task automatic test_done;
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial
	begin
		#200000;
		failures++;
		test_done();
	end
	initial
	begin
		cfg.out_type = 8'h0c;
		cfg.y_min = 16'h0100;
		cfg.y_max = 16'h0f00;
		cfg.forced_output_value = 16'h0777;
		cfg.fault_value = 16'h0555;
		cfg.freq_min = 16'h0010;
		cfg.freq_max = 16'h0200;
		cfg.current_tol = 16'h0010;
		do_reset();
		check(oval, 16'h0000);
		check(ofix, 16'h4000);
		set_src(0, 16'h8000);
		for (int i = 0; i < 9; i++)
		begin
			cfg.out_type = types[i];
			cyc(30);
			check(16'(oact), 16'h0001);
			check(oval, 16'h0f00);
		end
		cfg.out_type = 8'h00;
		cyc(30);
		check(oval, 16'h0000);
		cfg.out_type = 8'h0c;
		set_src(0, 16'h0000);
		check(oval, 16'h0100);
		// narrower source range: mid-range maps to half scale
		smin[15:0] = 16'h1000;
		smax[15:0] = 16'h3000;
		set_src(0, 16'h2000);
		check(oval, 16'h0800);
		set_src(0, 16'h0800);
		check(oval, 16'h0100);
		set_src(0, 16'h4000);
		check(oval, 16'h0f00);
		smin[15:0] = 16'h0000;
		smax[15:0] = 16'h8000;
		set_src(0, 16'h0000);
		check(oval, 16'h0100);
		cfg.y_min = 16'h0f00;
		cfg.y_max = 16'h0100;
		cyc(30);
		check(oval, 16'h0f00);
		cfg.y_min = 16'h0100;
		cfg.y_max = 16'h0f00;
		cfg.ramp_up_ms = 16'h0004;
		cyc(30);
		sval[15:0] = 16'h8000;
		cyc(15);
		check(16'(oval > 16'h0100 && oval < 16'h0f00), 16'h0001);
		cyc(50);
		check(oval, 16'h0f00);
		cfg.ramp_up_ms = 16'h0000;
		fdat = 16'h1234;
		fwr = 1'b1;
		cyc(1);
		fwr = 1'b0;
		cyc(2);
		check(ofix, 16'h1234);
		cfg.out_type = 8'h32;
		cyc(3);
		check(ofix, 16'h01f4);
		cfg.out_type = 8'h28;
		cyc(3);
		check(ofix, 16'h4000);
		cfg.out_type = 8'h46;
		set_src(3, 16'h8000);
		check(ofreq, 16'h0200);
		set_src(3, 16'h0000);
		check(ofreq, 16'h0010);
		cfg.out_type = 8'h15;
		cyc(30);
		check(16'(ifault), 16'h0000);
		ferr = 16'h0100;
		cyc(30);
		check(16'(ifault), 16'h0001);
		ferr = 16'h0000;
		cfg.out_type = 8'h0c;
		ovr_used = 1'b1;
		sdig[1] = 1'b1;
		set_src(1, 16'h0001);
		check(oval, 16'h0777);
		cfg.ovr_resp = 1'b1;
		cyc(30);
		check(oval, 16'h0f00);
		set_src(1, 16'h0000);
		check(oval, 16'h0777);
		sup_en = 1'b1;
		sup_flt = 1'b1;
		cyc(30);
		check(oval, 16'h0000);
		check(16'(oact), 16'h0000);
		sup_en = 1'b0;
		cyc(30);
		check(oval, 16'h0777);
		sup_flt = 1'b0;
		ot_en = 1'b1;
		ot = 1'b1;
		cyc(30);
		check(oval, 16'h0000);
		ot = 1'b0;
		cyc(30);
		check(oval, 16'h0777);
		ovr_used = 1'b0;
		cfg.en_used = 1'b1;
		sdig[2] = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			cfg.en_resp = etab[i][22:20];
			sval[32] = etab[i][16];
			cyc(30);
			check(oval, etab[i][15:0]);
		end
		set_src(0, 16'h0000);
		check(oval, 16'h0f00);
		cfg.en_used = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			set_src(0, 16'h8000);
			cfg.fault_resp = 2'(i);
			sflt[0] = 1'b1;
			set_src(0, 16'h0000);
			check(oval, fexp[i]);
			sflt[0] = 1'b0;
		end
		cfg.out_type = 8'h3c;
		sdig[0] = 1'b1;
		set_src(0, 16'h0001);
		check(16'(odig), 16'h0001);
		set_src(0, 16'h0000);
		check(16'(odig), 16'h0000);
		cfg.dig_resp = 2'h1;
		set_src(0, 16'h0001);
		check(16'(odig), 16'h0000);
		set_src(0, 16'h0000);
		check(16'(odig), 16'h0001);
		cfg.dig_resp = 2'h0;
		cfg.dig_delay_ms = 16'h0003;
		cyc(30);
		sval[0] = 1'b1;
		cyc(12);
		check(16'(odig), 16'h0000);
		cyc(40);
		check(16'(odig), 16'h0001);
		sval[0] = 1'b0;
		cyc(12);
		check(16'(odig), 16'h0000);
		// falling-edge polarity: rise passes, fall waits three ticks
		cfg.delay_pol = 1'b1;
		sval[0] = 1'b1;
		cyc(12);
		check(16'(odig), 16'h0001);
		sval[0] = 1'b0;
		cyc(12);
		check(16'(odig), 16'h0001);
		cyc(40);
		check(16'(odig), 16'h0000);
		cfg.delay_pol = 1'b0;
		cfg.dig_delay_ms = 16'h0000;
		cfg.dig_resp = 2'h2;
		do_reset();
		set_src(0, 16'h0001);
		check(16'(odig), 16'h0001);
		set_src(0, 16'h0000);
		check(16'(odig), 16'h0001);
		set_src(0, 16'h0001);
		check(16'(odig), 16'h0000);
		cfg.dig_resp = 2'h3;
		cfg.blink_ms = 16'h0002;
		n = 0;
		prev = odig;
		for (int i = 0; i < 100; i++)
		begin
			cyc(1);
			n += int'(odig != prev);
			prev = odig;
		end
		check(16'(n >= 3), 16'h0001);
		set_src(0, 16'h0000);
		check(16'(odig), 16'h0000);
		cfg.dig_resp = 2'h0;
		sdig[0] = 1'b0;
		set_src(0, 16'h8000);
		check(16'(odig), 16'h0001);
		set_src(0, 16'h4000);
		check(16'(odig), 16'h0001);
		set_src(0, 16'h0000);
		check(16'(odig), 16'h0000);
		set_src(0, 16'h4000);
		check(16'(odig), 16'h0000);
		ft = 2'h2;
		fc = 16'h0004;
		do_reset();
		sample(16'h0100);
		sample(16'h0200);
		sample(16'h0300);
		check(filt, 16'h0000);
		sample(16'h0600);
		check(filt, 16'h0300);
		ft = 2'h1;
		fc = 16'h0002;
		do_reset();
		sample(16'h0800);
		check(filt, 16'h0400);
		sample(16'h0800);
		check(filt, 16'h0600);
		test_done();
	end
endmodule : output_command_logic_bench
`default_nettype wire
